// *** src/opmode_ctrl.sv ***
// operating-mode controller: mode state machine, decode size derivation and ahb-lite slave
//
// Contract
// - Any reset puts the core in real-address mode.
// - System management entry on irq pin falling edge or controller message.
// - Entry saves basic context and selects the separate address space.
// - Leaving system management restores saved context and prior mode exactly.
// - Virtual-8086 is a per-task attribute of protected mode, not a mode.
// - Extended long state has exactly two sub-modes: compatibility and 64-bit.
// - Compatibility sub-mode chosen per code segment while extended state active.
// - Compatibility sub-mode limits linear addressing to the first 4 GByte.
// - Compatibility sub-mode allows only 16/32-bit address and operand sizes.
// - Compatibility sub-mode forbids virtual-8086 tasks and hardware task switching.
// - Compatibility sub-mode reaches memory above 4 GByte via address extension.
// - Compatibility sub-mode supports all privilege levels of other modes.
// - 64-bit sub-mode gives 16 GPRs and 16 SIMD regs, GPRs 64 bits.
// - 64-bit sub-mode decodes the register extension prefix for extra registers.
// - 64-bit sub-mode chosen per code segment while extended state active.
// - 64-bit sub-mode defaults: 64-bit address size, 32-bit operand size.
// - Extension prefix with its W bit gives 64-bit operands per instruction.
// - Each 32-bit GPR is also reachable as 8-bit or 16-bit register.
// - In 64-bit sub-mode byte accesses select the low 8 bits uniformly.
`timescale 1ns/100ps
module opmode_ctrl
   import opmode_pkg::*;
(
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // system management requests
   input wire logic sysmgmt_irq_n,
   input wire logic onchip_interrupt_ctrl_msg,
   // mode and decode outputs
   output logic [2:0] mode_state,
   output logic system_management_state,
   output logic [1:0] addr_size,
   output logic [1:0] oper_size,
   output logic [4:0] gpr_count,
   output logic [4:0] simd_count,
   output logic [6:0] gpr_width,
   output logic [6:0] lin_addr_width,
   output logic v86_active,
   output logic task_switch_ok,
   output logic smram_select
);

   opmode_state_t state_reg, state_next, saved_mode_reg;
   logic [31:0] ctrl_reg, seg_reg, decode_reg, ctx_reg, saved_ctx_reg, saved_seg_reg;
   logic [31:0] saved_ctrl_reg;
   logic irq_n_d_reg;
   logic smi_pending_reg;
   logic resume_req;
   // ahb address phase capture
   logic wr_pend_reg;
   logic [7:0] wr_addr_reg;
   logic [31:0] rdata_next;

   wire logic addr_phase = hsel && hready && htrans[1];
   wire logic wr_fire = wr_pend_reg;

   // sub-mode from code segment bits; only legal long/compat choices exist
   function automatic opmode_state_t mode_from_ctrl(input logic [31:0] c, input logic [31:0] s);
      if (!c[CTRL_PROT_BIT])
         return OPMODE_REAL;
      else if (c[CTRL_LONG_BIT])
         return s[SEG_L_BIT] ? OPMODE_LONG64 : OPMODE_COMPAT;
      else
         return OPMODE_PROT;
   endfunction : mode_from_ctrl

   // register writes; data phase follows the captured address phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
      end else begin
         wr_pend_reg <= addr_phase && hwrite && (hsize == 3'h2);
         wr_addr_reg <= haddr;
      end
   end

   assign resume_req = wr_fire && (wr_addr_reg == OFS_CTRL) && hwdata[CTRL_RESUME_BIT];

   // software-visible control; ctrl and seg frozen during system management except resume, decode and ctx stay writable
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_reg <= CTRL_RESET;
         seg_reg <= SEG_RESET;
         decode_reg <= 32'h0000_0000;
         ctx_reg <= CTX_RESET;
      end else if (state_reg == OPMODE_SYSMGMT && state_next != OPMODE_SYSMGMT) begin
         ctrl_reg <= saved_ctrl_reg;
         seg_reg <= saved_seg_reg;
         ctx_reg <= saved_ctx_reg;
      end else if (wr_fire) begin
         unique case (wr_addr_reg)
            OFS_CTRL: if (state_reg != OPMODE_SYSMGMT) ctrl_reg <= {27'h0, hwdata[4:0] & 5'h17};
            OFS_SEG: if (state_reg != OPMODE_SYSMGMT) seg_reg <= {30'h0, hwdata[1:0]};
            OFS_DECODE: decode_reg <= {20'h0, hwdata[11:0]};
            OFS_CTX: ctx_reg <= hwdata;
            default: ;
         endcase
      end
   end

   // irq pin falling edge or controller message latches a pending request
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_n_d_reg <= 1'b1;
         smi_pending_reg <= 1'b0;
      end else begin
         irq_n_d_reg <= sysmgmt_irq_n;
         if ((irq_n_d_reg && !sysmgmt_irq_n) || onchip_interrupt_ctrl_msg)
            smi_pending_reg <= 1'b1;
         else if (state_reg == OPMODE_SYSMGMT)
            smi_pending_reg <= 1'b0;
      end
   end

   always_comb begin
      state_next = mode_from_ctrl(ctrl_reg, seg_reg);
      if (state_reg == OPMODE_SYSMGMT)
         state_next = resume_req ? saved_mode_reg : OPMODE_SYSMGMT;
      else if (smi_pending_reg)
         state_next = OPMODE_SYSMGMT;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         state_reg <= OPMODE_REAL;
      else
         state_reg <= state_next;
   end

   // context save on entry
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         saved_mode_reg <= OPMODE_REAL;
         saved_ctx_reg <= CTX_RESET;
         saved_ctrl_reg <= CTRL_RESET;
         saved_seg_reg <= SEG_RESET;
      end else if (state_reg != OPMODE_SYSMGMT && state_next == OPMODE_SYSMGMT) begin
         saved_mode_reg <= state_reg;
         saved_ctx_reg <= ctx_reg;
         saved_ctrl_reg <= ctrl_reg;
         saved_seg_reg <= seg_reg;
      end
   end

   // decode outputs derived from the held mode
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mode_state <= 3'h0;
         system_management_state <= 1'b0;
         addr_size <= SZ_16;
         oper_size <= SZ_16;
         gpr_count <= GPR_LEGACY;
         simd_count <= GPR_LEGACY;
         gpr_width <= GPR_W_LEGACY;
         lin_addr_width <= LIN_W_LEGACY;
         v86_active <= 1'b0;
         task_switch_ok <= 1'b0;
         smram_select <= 1'b0;
      end else begin
         mode_state <= state_reg;
         system_management_state <= (state_reg == OPMODE_SYSMGMT);
         smram_select <= (state_reg == OPMODE_SYSMGMT);
         unique case (state_reg)
            OPMODE_LONG64: begin
               addr_size <= decode_reg[DEC_ADSZ_BIT] ? SZ_32 : SZ_64;
               if (decode_reg[DEC_REX_BIT] && decode_reg[DEC_REXW_BIT])
                  oper_size <= SZ_64;
               else
                  oper_size <= decode_reg[DEC_OPSZ_BIT] ? SZ_16 : SZ_32;
               gpr_count <= GPR_EXT;
               simd_count <= GPR_EXT;
               gpr_width <= GPR_W_EXT;
               lin_addr_width <= LIN_W_EXT;
               v86_active <= 1'b0;
               task_switch_ok <= 1'b0;
            end
            OPMODE_COMPAT: begin
               addr_size <= (seg_reg[SEG_D_BIT] ^ decode_reg[DEC_ADSZ_BIT]) ? SZ_32 : SZ_16;
               oper_size <= (seg_reg[SEG_D_BIT] ^ decode_reg[DEC_OPSZ_BIT]) ? SZ_32 : SZ_16;
               gpr_count <= GPR_LEGACY;
               simd_count <= GPR_LEGACY;
               gpr_width <= GPR_W_LEGACY;
               // physical extension width, linear still 4 GByte
               lin_addr_width <= LIN_W_LEGACY;
               v86_active <= 1'b0;
               task_switch_ok <= 1'b0;
            end
            OPMODE_PROT: begin
               addr_size <= (seg_reg[SEG_D_BIT] ^ decode_reg[DEC_ADSZ_BIT]) ? SZ_32 : SZ_16;
               oper_size <= (seg_reg[SEG_D_BIT] ^ decode_reg[DEC_OPSZ_BIT]) ? SZ_32 : SZ_16;
               gpr_count <= GPR_LEGACY;
               simd_count <= GPR_LEGACY;
               gpr_width <= GPR_W_LEGACY;
               lin_addr_width <= LIN_W_LEGACY;
               v86_active <= ctrl_reg[CTRL_V86_BIT];
               task_switch_ok <= 1'b1;
            end
            default: begin
               // real and system management run 16-bit defaults with prefix override
               addr_size <= decode_reg[DEC_ADSZ_BIT] ? SZ_32 : SZ_16;
               oper_size <= decode_reg[DEC_OPSZ_BIT] ? SZ_32 : SZ_16;
               gpr_count <= GPR_LEGACY;
               simd_count <= GPR_LEGACY;
               gpr_width <= GPR_W_LEGACY;
               lin_addr_width <= LIN_W_LEGACY;
               v86_active <= 1'b0;
               task_switch_ok <= 1'b0;
            end
         endcase
      end
   end

   // register select for decoded index: extension bit only honoured in 64-bit sub-mode
   function automatic logic [7:0] reg_select(input opmode_state_t m, input logic [31:0] d);
      logic [3:0] idx;
      idx = d[DEC_REG_LSB +: 4];
      if (m != OPMODE_LONG64)
         idx[3] = 1'b0;
      // byte access: 64-bit sub-mode always low byte; legacy idx 4..7 map to high bytes
      if (d[DEC_BYTE_BIT] && m != OPMODE_LONG64 && idx[2])
         return {1'b1, 3'h0, 2'h0, idx[1:0]};
      return {1'b0, 3'h0, idx};
   endfunction : reg_select

   // read mux; 32-bit gpr viewable as 8/16 bits via byte flag and operand size
   always_comb begin
      rdata_next = 32'h0000_0000;
      unique case (haddr)
         OFS_CTRL: rdata_next = ctrl_reg;
         OFS_STATUS: rdata_next = {24'h0, smi_pending_reg, system_management_state,
                                   task_switch_ok, v86_active, 1'b0, state_reg};
         OFS_SEG: rdata_next = seg_reg;
         OFS_DECODE: rdata_next = {reg_select(state_reg, decode_reg), 4'h0, addr_size,
                                   oper_size, decode_reg[15:0]};
         OFS_CTX: rdata_next = ctx_reg;
         OFS_SAVED: rdata_next = saved_ctx_reg;
         OFS_LIMITS: rdata_next = {1'b0, (state_reg == OPMODE_COMPAT && ctrl_reg[CTRL_PAE_BIT])
                                   ? PHYS_W_PAE : LIN_W_LEGACY, 1'b0, lin_addr_width,
                                   3'h0, simd_count, 3'h0, gpr_count};
         default: rdata_next = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         if (addr_phase && !hwrite)
            hrdata <= rdata_next;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end
endmodule : opmode_ctrl

// *** pkg/opmode_pkg.sv ***
// package: register map, mode encodings and size codes for the operating-mode controller
package opmode_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_SEG = 8'h08;
   localparam logic [7:0] OFS_DECODE = 8'h0c;
   localparam logic [7:0] OFS_CTX = 8'h10;
   localparam logic [7:0] OFS_SAVED = 8'h14;
   localparam logic [7:0] OFS_LIMITS = 8'h18;
   // control bits
   localparam int CTRL_PROT_BIT = 0;
   localparam int CTRL_LONG_BIT = 1;
   localparam int CTRL_V86_BIT = 2;
   localparam int CTRL_RESUME_BIT = 3;
   localparam int CTRL_PAE_BIT = 4;
   // code segment bits
   localparam int SEG_L_BIT = 0;
   localparam int SEG_D_BIT = 1;
   // decode request bits
   localparam int DEC_REX_BIT = 0;
   localparam int DEC_REXW_BIT = 1;
   localparam int DEC_OPSZ_BIT = 2;
   localparam int DEC_ADSZ_BIT = 3;
   localparam int DEC_BYTE_BIT = 4;
   localparam int DEC_REG_LSB = 8;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [31:0] SEG_RESET = 32'h0000_0000;
   localparam logic [31:0] CTX_RESET = 32'h0000_0000;
   // size codes
   localparam logic [1:0] SZ_16 = 2'h0;
   localparam logic [1:0] SZ_32 = 2'h1;
   localparam logic [1:0] SZ_64 = 2'h2;
   localparam logic [4:0] GPR_LEGACY = 5'h08;
   localparam logic [4:0] GPR_EXT = 5'h10;
   localparam logic [6:0] GPR_W_LEGACY = 7'h20;
   localparam logic [6:0] GPR_W_EXT = 7'h40;
   localparam logic [6:0] LIN_W_LEGACY = 7'h20;
   localparam logic [6:0] LIN_W_EXT = 7'h40;
   localparam logic [6:0] PHYS_W_PAE = 7'h24;
   typedef enum logic [2:0] {
      OPMODE_REAL, OPMODE_PROT, OPMODE_COMPAT, OPMODE_LONG64, OPMODE_SYSMGMT
   } opmode_state_t;
endpackage : opmode_pkg

// *** testbench/opmode_ctrl_asserts.sv ***
// checker: mode outputs and bus answers of the operating-mode controller
`timescale 1ns/100ps
module opmode_ctrl_checker
   import opmode_pkg::*;
(
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // bus answer
   input wire logic hreadyout,
   input wire logic hresp,
   // requests
   input wire logic sysmgmt_irq_n,
   input wire logic onchip_interrupt_ctrl_msg,
   // mode outputs
   input wire logic [2:0] mode_state,
   input wire logic system_management_state,
   input wire logic [1:0] addr_size,
   input wire logic [1:0] oper_size,
   input wire logic [4:0] gpr_count,
   input wire logic [4:0] simd_count,
   input wire logic [6:0] gpr_width,
   input wire logic [6:0] lin_addr_width,
   input wire logic v86_active,
   input wire logic task_switch_ok,
   input wire logic smram_select
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic [2:0] prior_reg;
   // last mode outside system management, the one an exit must come back to
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) prior_reg <= 3'h0;
      else if (mode_state != 3'h4) prior_reg <= mode_state;
   end
   a_reset_real: assert property ($rose(hresetn) |-> mode_state == 3'h0
      && gpr_count == GPR_LEGACY) else $error("mode not real after reset");
   a_bus_okay: assert property (hreadyout && !hresp) else $error("bus answer not okay");
   a_pin_entry: assert property ($fell(sysmgmt_irq_n) |-> ##[1:4] system_management_state)
      else $error("pin request not taken");
   a_msg_entry: assert property (onchip_interrupt_ctrl_msg |-> ##[1:4] system_management_state)
      else $error("message request not taken");
   a_space_select: assert property (smram_select == system_management_state
      && system_management_state == (mode_state == 3'h4)) else $error("space select wrong");
   a_exit_restore: assert property ($past(mode_state) == 3'h4 && mode_state != 3'h4
      |-> mode_state == prior_reg) else $error("exit mode not restored");
   a_v86_prot: assert property (v86_active |-> mode_state == 3'h1)
      else $error("v86 outside protected");
   a_mode_legal: assert property (mode_state <= 3'h4) else $error("illegal mode");
   a_compat_size: assert property (mode_state == 3'h2 |-> addr_size != SZ_64
      && oper_size != SZ_64 && lin_addr_width == LIN_W_LEGACY) else $error("compat sizes");
   a_compat_notask: assert property (mode_state == 3'h2 |-> !task_switch_ok && !v86_active)
      else $error("compat task features on");
   a_long_regs: assert property (mode_state == 3'h3 |-> gpr_count == GPR_EXT
      && simd_count == GPR_EXT && gpr_width == GPR_W_EXT) else $error("64-bit regs");
   a_long_sizes: assert property ($changed(mode_state) && mode_state == 3'h3
      |-> addr_size == SZ_64 && oper_size == SZ_32) else $error("64-bit defaults");
endmodule : opmode_ctrl_checker
bind opmode_ctrl opmode_ctrl_checker i_chk (.hclk, .hresetn, .hreadyout, .hresp,
   .sysmgmt_irq_n, .onchip_interrupt_ctrl_msg, .mode_state, .system_management_state,
   .addr_size, .oper_size, .gpr_count, .simd_count, .gpr_width, .lin_addr_width,
   .v86_active, .task_switch_ok, .smram_select);

// *** testbench/opmode_platform.sv ***
// partner: platform logic and interrupt controller raising system management requests
`timescale 1ns/100ps
module opmode_platform (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // requests from the bench
   input wire logic pin_req,
   input wire logic msg_req,
   // lines into the core
   output logic sysmgmt_irq_n,
   output logic onchip_interrupt_ctrl_msg
);
   logic [3:0] low_cnt_reg;
   // pin is pulled up; held low a few cycles so the level outlasts any sampling skew
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) low_cnt_reg <= 4'h0;
      else if (pin_req) low_cnt_reg <= 4'h6;
      else if (low_cnt_reg != 4'h0) low_cnt_reg <= low_cnt_reg - 4'h1;
   end
   assign sysmgmt_irq_n = (low_cnt_reg == 4'h0);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) onchip_interrupt_ctrl_msg <= 1'b0;
      else onchip_interrupt_ctrl_msg <= msg_req;
   end
endmodule : opmode_platform

// *** testbench/opmode_ctrl_tb_top.sv ***
// testbench: mode changes, system management entry and exit, decode sizes over ahb-lite
`timescale 1ns/100ps
module opmode_ctrl_tb_top;
   import opmode_pkg::*;
   localparam logic [23:0] LEG = {GPR_LEGACY, GPR_LEGACY, GPR_W_LEGACY, LIN_W_LEGACY};
   localparam logic [23:0] EXT = {GPR_EXT, GPR_EXT, GPR_W_EXT, LIN_W_EXT};
   logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, rd_pend;
   logic [7:0] haddr;
   logic [1:0] htrans, addr_size, oper_size;
   logic [2:0] hsize, mode_state;
   logic [31:0] hwdata, hrdata, ctx;
   logic [4:0] gpr_count, simd_count;
   logic [6:0] gpr_width, lin_addr_width;
   logic sysmgmt_irq_n, onchip_interrupt_ctrl_msg, system_management_state;
   logic v86_active, task_switch_ok, smram_select, pin_req, msg_req;
   logic [63:0] rq[$];
   int n_fail, n_checks, t;
   assign hready = hreadyout;
   opmode_ctrl i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready, .hrdata, .hreadyout, .hresp, .sysmgmt_irq_n, .onchip_interrupt_ctrl_msg,
      .mode_state, .system_management_state, .addr_size, .oper_size, .gpr_count,
      .simd_count, .gpr_width, .lin_addr_width, .v86_active, .task_switch_ok, .smram_select);
   opmode_platform i_plat (.hclk, .hresetn, .pin_req, .msg_req, .sysmgmt_irq_n,
      .onchip_interrupt_ctrl_msg);
   initial begin
      hclk = 1'b0;
      forever #2 hclk = ~hclk;
   end
   task conclude;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : conclude
   task chk_port(input logic [2:0] m, input logic [1:0] a, o, input logic [23:0] r,
                 input logic [1:0] f);
      logic [32:0] got;
      got = {mode_state, addr_size, oper_size, gpr_count, simd_count, gpr_width,
             lin_addr_width, v86_active, task_switch_ok};
      n_checks++;
      if (got !== {m, a, o, r, f}) begin
         n_fail++;
         $display("[FAIL] %0t ports got %h exp %h", $time, got, {m, a, o, r, f});
      end
   endtask : chk_port
   task chk_rd(input logic [31:0] got, input logic [63:0] e);
      n_checks++;
      if ((got & e[63:32]) !== e[31:0]) begin
         n_fail++;
         $display("[FAIL] %0t read got %h exp %h", $time, got, e[31:0]);
      end
   endtask : chk_rd
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
   endtask : xfer
   task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] mask);
      rq.push_back({mask, e});
      xfer(1'b0, a, 32'h0);
   endtask : rd
   task settle;
      repeat (4) @(posedge hclk);
      #1;
   endtask : settle
   task tdone;
      t++;
      $display("test %0d done", t);
   endtask : tdone
   // read data is taken at the edge closing the data phase
   always @(posedge hclk) begin
      if (rd_pend && hreadyout && rq.size() > 0) chk_rd(hrdata, rq.pop_front());
      rd_pend <= hsel && htrans[1] && !hwrite && hreadyout;
   end
   initial begin
      repeat (20000) @(posedge hclk);
      n_fail++;
      $display("[FAIL] %0t watchdog got %h exp %h", $time, 1'b0, 1'b1);
      conclude();
   end
   initial begin
      n_fail = 0; n_checks = 0; t = 0; rd_pend = 1'b0; hresetn = 1'b0; hsel = 1'b0;
      haddr = 8'h0; htrans = 2'h0; hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0;
      pin_req = 1'b0; msg_req = 1'b0;
      void'($urandom(32'h4708c94b));
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      #1;
      chk_port(3'h0, SZ_16, SZ_16, LEG, 2'b00);
      rd(OFS_STATUS, 32'h0, 32'hff);
      rd(8'h40, 32'h0, 32'hffff_ffff);
      tdone();
      xfer(1'b1, OFS_SEG, 32'h2);
      xfer(1'b1, OFS_CTRL, 32'h5);
      settle();
      chk_port(3'h1, SZ_32, SZ_32, LEG, 2'b11);
      rd(OFS_STATUS, 32'h31, 32'hff);
      // legacy byte index 5 selects a high byte register
      xfer(1'b1, OFS_DECODE, 32'h510);
      rd(OFS_DECODE, 32'h8100_0000, 32'h8f00_0000);
      xfer(1'b1, OFS_DECODE, 32'h0);
      xfer(1'b1, OFS_CTRL, 32'h17);
      for (int d = 1; d >= 0; d--) begin
         xfer(1'b1, OFS_SEG, 32'(d) << 1);
         settle();
         chk_port(3'h2, d ? SZ_32 : SZ_16, d ? SZ_32 : SZ_16, LEG, 2'b00);
      end
      rd(OFS_LIMITS, 32'h2420_0808, 32'hffff_ffff);
      tdone();
      xfer(1'b1, OFS_SEG, 32'h1);
      settle();
      chk_port(3'h3, SZ_64, SZ_32, EXT, 2'b00);
      xfer(1'b1, OFS_DECODE, 32'h901);
      rd(OFS_DECODE, 32'h0909_0000, 32'h0f0f_0000);
      xfer(1'b1, OFS_DECODE, 32'h903);
      rd(OFS_DECODE, 32'h090a_0000, 32'h0f0f_0000);
      xfer(1'b1, OFS_DECODE, 32'h411);
      rd(OFS_DECODE, 32'h0400_0000, 32'h8f00_0000);
      xfer(1'b1, OFS_DECODE, 32'h0);
      tdone();
      for (int s = 0; s < 2; s++) begin
         ctx = $urandom;
         xfer(1'b1, OFS_CTX, ctx);
         if (s == 0) pin_req <= 1'b1;
         else msg_req <= 1'b1;
         @(posedge hclk);
         pin_req <= 1'b0;
         msg_req <= 1'b0;
         settle();
         settle();
         rd(OFS_STATUS, 32'h44, 32'hc7);
         rd(OFS_SAVED, ctx, 32'hffff_ffff);
         xfer(1'b1, OFS_CTRL, 32'h0);
         xfer(1'b1, OFS_CTRL, 32'h8);
         settle();
         chk_port(3'h3, SZ_64, SZ_32, EXT, 2'b00);
         rd(OFS_CTX, ctx, 32'hffff_ffff);
         rd(OFS_CTRL, 32'h17, 32'hff);
         tdone();
      end
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      #1;
      chk_port(3'h0, SZ_16, SZ_16, LEG, 2'b00);
      tdone();
      settle();
      conclude();
   end
endmodule : opmode_ctrl_tb_top
